// >>> pkg/conv_defs.svh
`ifndef CONV_DEFS_SVH
`define CONV_DEFS_SVH
// --------------------------------------------------
// Register addresses
// --------------------------------------------------
`define A_STATUS 32'hFFFF0500
`define A_MASK 32'hFFFF0504
`define A_MODE 32'hFFFF0508
`define A_PCTL 32'hFFFF050C
`define A_ACTL 32'hFFFF0510
`define A_FILT 32'hFFFF0514
`define A_CFG 32'hFFFF0518
`define A_EXC 32'hFFFF051C
`define A_PDAT 32'hFFFF0520
`define A_ADAT 32'hFFFF0524
`define A_THR 32'hFFFF0528
`define A_TCNT 32'hFFFF052C
`define A_TLIM 32'hFFFF0530
`define A_ACC 32'hFFFF0534
// --------------------------------------------------
// Field positions
// --------------------------------------------------
`define F_GAIN 3:0
`define F_DIAG 5:4
`define F_PREF 7:6
`define F_AREF 8:6
`define B_PHIREF 8
`define B_AHIREF 9
`define F_AMUX 3:0
`define B_EN 15
`define F_DECIM 6:0
`define B_CHOP 15
`define F_EXCITATION_CURRENT_LEVEL 3:0
`define B_STEER0 4
`define B_STEER1 5
`define B_EXC0 6
`define B_EXC1 7
`define F_PWR 4:3
`define B_LP 5
`define B_FASTCLK 7
`define F_CMP 4:3
`define F_ACCM 6:5
`define ST_PRDY 0
`define ST_ARDY 1
`define ST_CNT 3
`define ST_CMP 4
`define ST_PERR 12
`define ST_AERR 13
`define ST_CAL 15
// --------------------------------------------------
// Reset values and limits
// --------------------------------------------------
`define STATUS_RST 16'h0000
`define CTL_RST 16'h0000
`define GAIN_MAX 4'h9
`define EXCITATION_CURRENT_LEVEL_MAX 4'h5
`define SF_MIN 7'h03
`define AMUX_TEMP 4'hB
`define FS_POS 24'h7FFFFF
`define FS_NEG 24'h800000
`endif

// >>> pkg/conv_pkg.sv
package conv_pkg;
  typedef struct packed {
    logic [23:0] pri;
    logic [23:0] aux;
    logic pri_over;
    logic pri_under;
    logic aux_over;
    logic aux_under;
  } sample_t;
  typedef struct packed {
    logic [31:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } mmr_req_t;
  typedef struct packed {
    logic [15:0] pctl;
    logic [15:0] actl;
    logic [15:0] filt;
    logic [7:0] exc;
    logic [7:0] mode;
    logic [7:0] cfg;
    logic [15:0] mask;
    logic [23:0] thr;
    logic [15:0] tlim;
  } regs_t;
  typedef struct packed {
    logic [1:0] pri_ref;
    logic [2:0] aux_ref;
    logic pri_hiref;
    logic aux_hiref;
    logic [1:0] pri_diag;
    logic [1:0] aux_diag;
    logic [3:0] gain;
    logic [3:0] aux_mux;
    logic temp_sel;
    logic [1:0] exc_en;
    logic [3:0] exc_level;
    logic [1:0] exc_steer;
    logic low_power;
    logic pga_off;
    logic fast_clk;
    logic chop_swap;
    logic pri_en;
    logic aux_en;
  } ana_ctl_t;
  typedef enum logic [1:0] {CMP_OFF, CMP_ONLY, CMP_CNT_ABOVE, CMP_CNT_BELOW} cmp_mode_t;
  typedef enum logic [1:0] {ACC_OFF, ACC_ADD, ACC_SUB, ACC_HOLD} acc_mode_t;
  typedef enum logic [1:0] {PWR_NORMAL, PWR_LOW, PWR_LOW_PLUS, PWR_RSVD} pwr_mode_t;
endpackage

// >>> rtl/dual_adc_digital_control.sv
`timescale 1ns/10ps
`include "conv_defs.svh"
// Contract
// - Both converters default to internal reference
// - Test current field: off, first, both
// - Seven-bit word sets sinc decimation factor
// - Chop swaps inputs, averages successive outputs
// - Four-bit field selects ten gains
// - Bits 6 and 7 enable sources
// - Four-bit level in 200 uA steps
// - Steering bits route both sources one pin
// - Low power caps rate at 2 kHz
// - Normal, low-power, low-power-plus without amplifier
// - Comparator flags magnitude above threshold
// - Counter flags when count reaches limit
// - 32-bit accumulator adds or subtracts results
// - Each status source has a mask bit
// - Data reads clear result-ready bits
// - No overwrite until ready cleared, except sleep
// - Status register read-only, resets to zero
// - Auxiliary mux offers temperature channel
// - Out-of-range clamps result, sets error bit
// - Calibration bit set on completion, cleared on mode write
module dual_adc_digital_control #(
  parameter int DEPTH = 2
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire conv_pkg::mmr_req_t mmr_in,
  output logic [31:0] rdata_out,
  input wire conv_pkg::sample_t sample_in,
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  input wire logic cal_done_in,
  input wire logic core_sleep_in,
  output conv_pkg::ana_ctl_t ana_ctl_out,
  output logic irq_out
);
  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("DEPTH must be a power of two, at least 2");
    end
  end

  // --------------------------------------------------
  // Helpers
  // --------------------------------------------------
  function automatic logic [1:0] diag_map(input logic [1:0] f);
    diag_map = {f == 2'h3, f == 2'h1 || f == 2'h3};
  endfunction

  function automatic logic [23:0] clamp(input logic [23:0] v, input logic ov, input logic un);
    clamp = ov ? `FS_POS : (un ? `FS_NEG : v);
  endfunction

  function automatic logic [23:0] avg(input logic [23:0] a, input logic [23:0] b);
    logic [24:0] s;
    s = {a[23], a} + {b[23], b};
    avg = s[24:1];
  endfunction

  function automatic logic [23:0] mag(input logic [23:0] v);
    mag = v[23] ? 24'(-v) : v;
  endfunction

  // --------------------------------------------------
  // State
  // --------------------------------------------------
  conv_pkg::regs_t regs_reg, regs_next;
  conv_pkg::ana_ctl_t ctl_reg, ctl_next;
  conv_pkg::sample_t fifo_mem [DEPTH];
  conv_pkg::sample_t s;
  logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [PW:0] cnt_reg, cnt_next;
  logic rdy_reg, rdy_next;
  logic [15:0] status_reg, status_next;
  logic [23:0] pdat_reg, pdat_next, adat_reg, adat_next;
  logic [23:0] pprev_reg, pprev_next, aprev_reg, aprev_next;
  logic [6:0] dcnt_reg, dcnt_next, decim;
  logic [15:0] tcnt_reg, tcnt_next;
  logic [31:0] acc_reg, acc_next, rdata_reg, rdata_next;
  logic chop_reg, chop_next, irq_reg, irq_next;
  logic push, pop, stall, emit, p_write, a_write, pen, aen, above;
  logic [23:0] pc, ac, pout, aout;
  logic [15:0] clr;

  assign pen = regs_reg.pctl[`B_EN];
  assign aen = regs_reg.actl[`B_EN];

  // --------------------------------------------------
  // Sample buffer
  // --------------------------------------------------
  always_comb begin
    push = sample_valid_in && rdy_reg;
    stall = !core_sleep_in && (pen || aen) && (!pen || status_reg[`ST_PRDY]) && (!aen || status_reg[`ST_ARDY]);
    pop = (cnt_reg != '0) && !stall;
    wp_next = push ? PW'(wp_reg + 1'b1) : wp_reg;
    rp_next = pop ? PW'(rp_reg + 1'b1) : rp_reg;
    cnt_next = PW'(0) + cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    rdy_next = cnt_next < (PW+1)'(DEPTH);
  end

  // --------------------------------------------------
  // Converter datapath and registers
  // --------------------------------------------------
  always_comb begin
    regs_next = regs_reg;
    status_next = status_reg;
    pdat_next = pdat_reg;
    adat_next = adat_reg;
    pprev_next = pprev_reg;
    aprev_next = aprev_reg;
    tcnt_next = tcnt_reg;
    acc_next = acc_reg;
    chop_next = chop_reg;
    rdata_next = rdata_reg;
    clr = 16'h0000;
    s = fifo_mem[rp_reg];
    decim = regs_reg.filt[`F_DECIM];
    if (regs_reg.mode[`B_LP] && decim < `SF_MIN) begin
      decim = `SF_MIN;
    end
    emit = pop && (dcnt_reg >= 7'(decim - 7'h01));
    dcnt_next = pop ? (emit ? 7'h00 : 7'(dcnt_reg + 7'h01)) : dcnt_reg;
    pc = clamp(s.pri, s.pri_over, s.pri_under);
    ac = clamp(s.aux, s.aux_over, s.aux_under);
    pout = regs_reg.filt[`B_CHOP] ? avg(pc, pprev_reg) : pc;
    aout = regs_reg.filt[`B_CHOP] ? avg(ac, aprev_reg) : ac;
    if (emit) begin
      pprev_next = pc;
      aprev_next = ac;
      chop_next = regs_reg.filt[`B_CHOP] ? !chop_reg : 1'b0;
    end
    above = mag(pout) > regs_reg.thr;
    if (mmr_in.wr) begin
      unique case (mmr_in.addr)
        `A_MASK: regs_next.mask = mmr_in.wdata[15:0];
        `A_MODE: begin
          regs_next.mode = mmr_in.wdata[7:0];
          clr[`ST_CAL] = 1'b1;
        end
        `A_PCTL: regs_next.pctl = mmr_in.wdata[15:0];
        `A_ACTL: regs_next.actl = mmr_in.wdata[15:0];
        `A_FILT: regs_next.filt = mmr_in.wdata[15:0];
        `A_CFG: begin
          regs_next.cfg = mmr_in.wdata[7:0];
          tcnt_next = 16'h0000;
          clr[`ST_CNT] = 1'b1;
        end
        `A_EXC: regs_next.exc = mmr_in.wdata[7:0];
        `A_THR: regs_next.thr = mmr_in.wdata[23:0];
        `A_TLIM: begin
          regs_next.tlim = mmr_in.wdata[15:0];
          tcnt_next = 16'h0000;
          clr[`ST_CNT] = 1'b1;
        end
        `A_ACC: acc_next = 32'h00000000;
        default: ;
      endcase
    end
    if (mmr_in.rd) begin
      unique case (mmr_in.addr)
        `A_STATUS: rdata_next = {16'h0000, status_reg};
        `A_MASK: rdata_next = {16'h0000, regs_reg.mask};
        `A_MODE: rdata_next = {24'h000000, regs_reg.mode};
        `A_PCTL: rdata_next = {16'h0000, regs_reg.pctl};
        `A_ACTL: rdata_next = {16'h0000, regs_reg.actl};
        `A_FILT: rdata_next = {16'h0000, regs_reg.filt};
        `A_CFG: rdata_next = {24'h000000, regs_reg.cfg};
        `A_EXC: rdata_next = {24'h000000, regs_reg.exc};
        `A_THR: rdata_next = {8'h00, regs_reg.thr};
        `A_TCNT: rdata_next = {16'h0000, tcnt_reg};
        `A_TLIM: rdata_next = {16'h0000, regs_reg.tlim};
        `A_ACC: rdata_next = acc_reg;
        `A_PDAT: begin
          rdata_next = {{8{pdat_reg[23]}}, pdat_reg};
          clr[`ST_PRDY] = 1'b1;
        end
        `A_ADAT: begin
          rdata_next = {{8{adat_reg[23]}}, adat_reg};
          clr[`ST_ARDY] = 1'b1;
          clr[`ST_PRDY] = !pen;
        end
        default: rdata_next = 32'h00000000;
      endcase
    end
    status_next = status_reg & ~clr;
    p_write = emit && pen && (!status_reg[`ST_PRDY] || core_sleep_in);
    a_write = emit && aen && (!status_reg[`ST_ARDY] || core_sleep_in);
    if (p_write) begin
      pdat_next = pout;
      status_next[`ST_PRDY] = 1'b1;
      status_next[`ST_PERR] = s.pri_over || s.pri_under;
    end
    if (a_write) begin
      adat_next = aout;
      status_next[`ST_ARDY] = 1'b1;
      status_next[`ST_AERR] = s.aux_over || s.aux_under;
    end
    if (emit && pen) begin
      if (conv_pkg::cmp_mode_t'(regs_reg.cfg[`F_CMP]) != conv_pkg::CMP_OFF) begin
        status_next[`ST_CMP] = above;
      end
      if ((conv_pkg::cmp_mode_t'(regs_reg.cfg[`F_CMP]) == conv_pkg::CMP_CNT_ABOVE && above) ||
          (conv_pkg::cmp_mode_t'(regs_reg.cfg[`F_CMP]) == conv_pkg::CMP_CNT_BELOW && !above)) begin
        tcnt_next = 16'(tcnt_reg + 16'h0001);
        if (tcnt_next == regs_reg.tlim) begin
          status_next[`ST_CNT] = 1'b1;
          tcnt_next = 16'h0000;
        end
      end
      unique case (conv_pkg::acc_mode_t'(regs_reg.cfg[`F_ACCM]))
        conv_pkg::ACC_ADD: acc_next = acc_reg + {{8{pout[23]}}, pout};
        conv_pkg::ACC_SUB: acc_next = acc_reg - {{8{pout[23]}}, pout};
        conv_pkg::ACC_OFF, conv_pkg::ACC_HOLD: ;
      endcase
    end
    if (cal_done_in) begin
      status_next[`ST_CAL] = 1'b1;
    end
    irq_next = |(status_reg & regs_reg.mask);
  end

  // --------------------------------------------------
  // Analog control outputs
  // --------------------------------------------------
  always_comb begin
    ctl_next.pri_ref = regs_reg.pctl[`F_PREF];
    ctl_next.aux_ref = regs_reg.actl[`F_AREF];
    ctl_next.pri_hiref = regs_reg.pctl[`B_PHIREF];
    ctl_next.aux_hiref = regs_reg.actl[`B_AHIREF];
    ctl_next.pri_diag = diag_map(regs_reg.pctl[`F_DIAG]);
    ctl_next.aux_diag = diag_map(regs_reg.actl[`F_DIAG]);
    ctl_next.gain = (regs_reg.pctl[`F_GAIN] > `GAIN_MAX) ? `GAIN_MAX : regs_reg.pctl[`F_GAIN];
    ctl_next.aux_mux = regs_reg.actl[`F_AMUX];
    ctl_next.temp_sel = regs_reg.actl[`F_AMUX] == `AMUX_TEMP;
    ctl_next.exc_en = {regs_reg.exc[`B_EXC1], regs_reg.exc[`B_EXC0]};
    ctl_next.exc_level = (regs_reg.exc[`F_EXCITATION_CURRENT_LEVEL] > `EXCITATION_CURRENT_LEVEL_MAX) ? `EXCITATION_CURRENT_LEVEL_MAX : regs_reg.exc[`F_EXCITATION_CURRENT_LEVEL];
    ctl_next.exc_steer = {regs_reg.exc[`B_STEER1], regs_reg.exc[`B_STEER0]};
    ctl_next.low_power = regs_reg.mode[`B_LP];
    ctl_next.pga_off = conv_pkg::pwr_mode_t'(regs_reg.mode[`F_PWR]) == conv_pkg::PWR_LOW_PLUS;
    ctl_next.fast_clk = regs_reg.mode[`B_FASTCLK];
    ctl_next.chop_swap = chop_reg;
    ctl_next.pri_en = pen;
    ctl_next.aux_en = aen;
  end

  // --------------------------------------------------
  // Registers
  // --------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      fifo_mem[wp_reg] <= sample_in;
    end
    if (rst_in) begin
      regs_reg <= '0;
      regs_reg.pctl <= `CTL_RST;
      regs_reg.actl <= `CTL_RST;
      ctl_reg <= '0;
      status_reg <= `STATUS_RST;
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b0;
      pdat_reg <= '0;
      adat_reg <= '0;
      pprev_reg <= '0;
      aprev_reg <= '0;
      dcnt_reg <= '0;
      tcnt_reg <= '0;
      acc_reg <= '0;
      rdata_reg <= '0;
      chop_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      regs_reg <= regs_next;
      ctl_reg <= ctl_next;
      status_reg <= status_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
      pdat_reg <= pdat_next;
      adat_reg <= adat_next;
      pprev_reg <= pprev_next;
      aprev_reg <= aprev_next;
      dcnt_reg <= dcnt_next;
      tcnt_reg <= tcnt_next;
      acc_reg <= acc_next;
      rdata_reg <= rdata_next;
      chop_reg <= chop_next;
      irq_reg <= irq_next;
    end
  end

  assign rdata_out = rdata_reg;
  assign sample_ready_out = rdy_reg;
  assign ana_ctl_out = ctl_reg;
  assign irq_out = irq_reg;

  // --------------------------------------------------
  // Assertions
  // --------------------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_ref_default: assert property ($fell(rst_in) |-> ana_ctl_out.pri_ref == 2'h0 && ana_ctl_out.aux_ref == 3'h0)
    else $error("reference not internal after reset");
  a_diag_map: assert property (regs_reg.pctl[`F_DIAG] == 2'h1 |=> ana_ctl_out.pri_diag == 2'h1)
    else $error("diag value 1 must enable first input only");
  a_gain_range: assert property (ana_ctl_out.gain <= `GAIN_MAX)
    else $error("gain code out of range");
  a_level_cap: assert property (ana_ctl_out.exc_level <= `EXCITATION_CURRENT_LEVEL_MAX)
    else $error("excitation level above 1 mA");
  a_lp_rate: assert property (emit && regs_reg.mode[`B_LP] |-> dcnt_reg >= 7'h02)
    else $error("low power rate too high");
  a_read_clear: assert property (mmr_in.rd && mmr_in.addr == `A_PDAT && !p_write |=> !status_reg[`ST_PRDY])
    else $error("primary ready not cleared by read");
  a_no_overwrite: assert property (status_reg[`ST_PRDY] && !core_sleep_in |=> $stable(pdat_reg))
    else $error("primary data overwritten while ready");
  a_status_reset: assert property ($fell(rst_in) |-> status_reg == 16'h0000)
    else $error("status not zero after reset");
  a_clamp_over: assert property (p_write && s.pri_over && !regs_reg.filt[`B_CHOP] |=>
    pdat_reg == `FS_POS && status_reg[`ST_PERR])
    else $error("overrange not clamped");
  a_cal_clear: assert property (mmr_in.wr && mmr_in.addr == `A_MODE && !cal_done_in |=> !status_reg[`ST_CAL])
    else $error("calibration bit not cleared by mode write");
  a_irq_mask: assert property (irq_out == $past(|(status_reg & regs_reg.mask)))
    else $error("interrupt does not follow masked status");

  c_full_buffer: cover property (!rdy_reg ##1 pop);
  c_chop_result: cover property (p_write && regs_reg.filt[`B_CHOP]);
  c_count_event: cover property (!status_reg[`ST_CNT] ##1 status_reg[`ST_CNT]);
endmodule

// >>> tb/modulator_model.sv
`timescale 1ns/10ps
module modulator_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [31:0] want_in,
  input wire logic slow_in,
  input wire conv_pkg::sample_t val_in,
  input wire logic ready_in,
  output conv_pkg::sample_t sample_out,
  output logic valid_out,
  output logic [31:0] sent_out
);
  conv_pkg::sample_t hold_reg;
  logic slow_reg;
  logic [31:0] nxt;
  logic launch;
  // --------------------------------------------------
  // Offer samples until the wanted count is taken
  // --------------------------------------------------
  assign nxt = sent_out + 32'(valid_out && ready_in);
  assign launch = (nxt < want_in) && (!slow_in || slow_reg);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      valid_out <= 1'b0;
      sent_out <= 32'h0;
      slow_reg <= 1'b0;
      hold_reg <= '0;
    end else begin
      slow_reg <= ~slow_reg;
      sent_out <= nxt;
      if (!valid_out || ready_in) begin
        valid_out <= launch;
        hold_reg <= val_in;
      end
    end
  end
  // Idle lines show the inverse of the last word
  assign sample_out = valid_out ? hold_reg : ~hold_reg;
endmodule

// >>> tb/test_dual_adc_digital_control.sv
`timescale 1ns/10ps
`include "conv_defs.svh"
module test_dual_adc_digital_control;
  typedef struct {
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] r;
    int s;
    logic [7:0] f;
  } row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  conv_pkg::mmr_req_t mmr = '0;
  conv_pkg::sample_t val = '0;
  conv_pkg::sample_t smp;
  conv_pkg::ana_ctl_t ana;
  logic [31:0] rdata;
  logic smp_valid;
  logic smp_ready;
  logic cal_done = 1'b0;
  logic sleep = 1'b0;
  logic slow = 1'b0;
  logic irq;
  logic [31:0] want = 32'h0;
  logic [31:0] sent;
  logic [31:0] d;
  int bad_count = 0;
  int total_checks = 0;
  row_t rows [15] = '{
    '{`A_PCTL, 32'h10, 32'h10, 0, 8'h01}, '{`A_PCTL, 32'h30, 32'h30, 0, 8'h03},
    '{`A_PCTL, 32'h20, 32'h20, 0, 8'h00}, '{`A_PCTL, 32'h09, 32'h09, 1, 8'h09},
    '{`A_PCTL, 32'h0F, 32'h0F, 1, 8'h09}, '{`A_PCTL, 32'h1C0, 32'h1C0, 2, 8'h07},
    '{`A_EXC, 32'hC3, 32'hC3, 3, 8'h33}, '{`A_EXC, 32'h77, 32'h77, 3, 8'hD5},
    '{`A_ACTL, 32'h0B, 32'h0B, 4, 8'h1B}, '{`A_MODE, 32'h30, 32'h30, 5, 8'h03},
    '{`A_MODE, 32'h28, 32'h28, 5, 8'h02}, '{`A_MODE, 32'h00, 32'h00, 5, 8'h00},
    '{`A_FILT, 32'h807F, 32'h807F, 7, 8'h00}, '{`A_STATUS, 32'hFFFF, 32'h0, 7, 8'h00},
    '{32'hFFFF05FC, 32'hFFFF, 32'h0, 7, 8'h00}};

  dual_adc_digital_control #(.DEPTH(2)) dut (
    .ref_clk_in(ref_clk), .rst_in(rst), .mmr_in(mmr), .rdata_out(rdata), .sample_in(smp),
    .sample_valid_in(smp_valid), .sample_ready_out(smp_ready), .cal_done_in(cal_done),
    .core_sleep_in(sleep), .ana_ctl_out(ana), .irq_out(irq));
  modulator_model model (
    .clk_in(ref_clk), .rst_in(rst), .want_in(want), .slow_in(slow), .val_in(val),
    .ready_in(smp_ready), .sample_out(smp), .valid_out(smp_valid), .sent_out(sent));

  always #4 ref_clk = ~ref_clk;
  // --------------------------------------------------
  // Bench tasks
  // --------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    want = 32'h0;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    mmr.addr = a;
    mmr.wdata = v;
    mmr.wr = 1'b1;
    @(negedge ref_clk);
    mmr.wr = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    mmr.addr = a;
    mmr.rd = 1'b1;
    @(negedge ref_clk);
    mmr.rd = 1'b0;
    @(negedge ref_clk);
    v = rdata;
  endtask
  task automatic feed(input int k, input logic [23:0] p, input logic [23:0] x, input logic [3:0] fl);
    val = {p, x, fl};
    want = want + 32'(k);
  endtask
  task automatic wait_sent();
    for (int i = 0; i < 200 && sent != want; i++) @(negedge ref_clk);
    chk(sent, want);
  endtask
  task automatic wait_bit(input int b);
    wait_sent();
    d = 32'h0;
    for (int i = 0; i < 30 && d[b] !== 1'b1; i++) rd(`A_STATUS, d);
    chk(32'(d[b]), 32'h1);
  endtask
  task automatic setup(input logic [31:0] filt);
    do_reset();
    wr(`A_PCTL, 32'h8000);
    wr(`A_FILT, filt);
  endtask
  function automatic logic [7:0] fld(input int s);
    case (s)
      0: fld = {6'h0, ana.pri_diag};
      1: fld = {4'h0, ana.gain};
      2: fld = {5'h0, ana.pri_hiref, ana.pri_ref};
      3: fld = {ana.exc_steer, ana.exc_en, ana.exc_level};
      4: fld = {3'h0, ana.temp_sel, ana.aux_mux};
      5: fld = {6'h0, ana.low_power, ana.pga_off};
      default: fld = 8'h0;
    endcase
  endfunction
  // --------------------------------------------------
  // Tests
  // --------------------------------------------------
  initial begin
    do_reset();
    chk(32'({ana.pri_ref, ana.aux_ref, ana.low_power, irq}), 32'h0);
    rd(`A_STATUS, d);
    chk(d, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, d);
      chk(d, rows[i].r);
      chk(32'(fld(rows[i].s)), 32'(rows[i].f));
    end
    $display("table done");
    setup(32'h3);
    feed(2, 24'h000123, 24'h0, 4'h0);
    wait_sent();
    repeat (8) @(negedge ref_clk);
    rd(`A_STATUS, d);
    chk(32'(d[0]), 32'h0);
    feed(1, 24'h000123, 24'h0, 4'h0);
    wait_bit(0);
    feed(3, 24'h000456, 24'h0, 4'h0);
    repeat (20) @(negedge ref_clk);
    chk(sent, 32'd5);
    chk(32'(smp_ready), 32'h0);
    rd(`A_PDAT, d);
    chk(d, 32'h123);
    wait_bit(0);
    rd(`A_PDAT, d);
    chk(d, 32'h456);
    feed(3, 24'h000789, 24'h0, 4'h0);
    wait_bit(0);
    sleep = 1'b1;
    feed(3, 24'h000ABC, 24'h0, 4'h0);
    wait_sent();
    repeat (8) @(negedge ref_clk);
    rd(`A_PDAT, d);
    chk(d, 32'hABC);
    rd(`A_STATUS, d);
    chk(32'(d[0]), 32'h0);
    sleep = 1'b0;
    $display("decimation done");
    setup(32'h3);
    wr(`A_ACTL, 32'h8000);
    feed(3, 24'h000010, 24'hFFFFF0, 4'h0);
    wait_bit(1);
    rd(`A_ADAT, d);
    chk(d, 32'hFFFFFFF0);
    rd(`A_PDAT, d);
    chk(d, 32'h10);
    feed(3, 24'h000010, 24'hFFFFF0, 4'h0);
    wait_bit(0);
    wr(`A_PCTL, 32'h0);
    rd(`A_ADAT, d);
    rd(`A_STATUS, d);
    chk(d & 32'h3, 32'h0);
    $display("aux done");
    setup(32'h3);
    slow = 1'b1;
    feed(3, 24'h000123, 24'h0, 4'h8);
    wait_bit(0);
    chk(32'(d[12]), 32'h1);
    rd(`A_PDAT, d);
    chk(d, 32'h007FFFFF);
    feed(3, 24'h000123, 24'h0, 4'h4);
    wait_bit(0);
    rd(`A_PDAT, d);
    chk(d, 32'hFF800000);
    feed(3, 24'h000055, 24'h0, 4'h0);
    wait_bit(0);
    chk(32'(d[12]), 32'h0);
    slow = 1'b0;
    $display("range done");
    do_reset();
    cal_done = 1'b1;
    @(negedge ref_clk);
    cal_done = 1'b0;
    rd(`A_STATUS, d);
    chk(32'({d[15], irq}), 32'h2);
    wr(`A_MASK, 32'h8000);
    repeat (2) @(negedge ref_clk);
    chk(32'(irq), 32'h1);
    wr(`A_MODE, 32'h0);
    repeat (2) @(negedge ref_clk);
    chk(32'(irq), 32'h0);
    $display("interrupt done");
    setup(32'h3);
    wr(`A_THR, 32'h100);
    wr(`A_CFG, 32'h08);
    wr(`A_MASK, 32'h10);
    feed(3, 24'hFFFF00, 24'h0, 4'h0);
    wait_bit(0);
    chk(32'({d[4], irq}), 32'h0);
    rd(`A_PDAT, d);
    feed(3, 24'hFFFE00, 24'h0, 4'h0);
    wait_bit(0);
    chk(32'({d[4], irq}), 32'h3);
    rd(`A_PDAT, d);
    wr(`A_CFG, 32'h30);
    wr(`A_TLIM, 32'h2);
    wr(`A_ACC, 32'h0);
    for (int n = 1; n <= 2; n++) begin
      feed(3, 24'h000200, 24'h0, 4'h0);
      wait_bit(0);
      chk(32'(d[3]), 32'(n == 2));
      rd(`A_PDAT, d);
      rd(`A_TCNT, d);
      chk(d, 32'(n % 2));
      rd(`A_ACC, d);
      chk(d, 32'h200 * 32'(n));
    end
    wr(`A_CFG, 32'h40);
    wr(`A_ACC, 32'h0);
    feed(3, 24'h000200, 24'h0, 4'h0);
    wait_bit(0);
    rd(`A_ACC, d);
    chk(d, 32'hFFFFFE00);
    $display("compare done");
    setup(32'h8003);
    feed(3, 24'h000100, 24'h0, 4'h0);
    wait_bit(0);
    rd(`A_PDAT, d);
    feed(3, 24'h000300, 24'h0, 4'h0);
    wait_bit(0);
    rd(`A_PDAT, d);
    chk(d, 32'h200);
    $display("chop done");
    results();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    results();
  end
endmodule
